// ==== bench/serial_peer.sv ====
// Purpose: Behavioural serial peripheral on the far side of the line
// Assumes: Fixed bit time of BIT system clocks, optional parity, one stop bit
// Notes:   Sends on request, reports each character it receives
`timescale 1ns/1ps
`default_nettype none

module serial_peer #(
    parameter int BIT = 64
) (
    input  wire logic       clk_in,
    input  wire logic       line_in,
    output logic            line_out,
    input  wire logic [3:0] nbits_in,
    input  wire logic [1:0] par_in,
    input  wire logic       send_in,
    input  wire logic [7:0] send_byte_in,
    output logic            got_out,
    output logic [7:0]      got_byte_out
);
    int         j;
    int         k;
    logic [7:0] v;

    initial begin
        line_out = 1'b1;
        got_out = 1'b0;
        got_byte_out = 8'h00;
    end

    // Start low, data LSB first, stop high; line idles high
    always @(posedge clk_in) begin
        if (send_in === 1'b1) begin
            line_out <= 1'b0;
            repeat (BIT) @(posedge clk_in);
            for (j = 0; j < nbits_in; j++) begin
                line_out <= send_byte_in[j];
                repeat (BIT) @(posedge clk_in);
            end
            // Parity bit when par_in[0] is set, even parity when par_in[1] is set
            if (par_in[0]) begin
                line_out <= par_in[1] ? ^send_byte_in : ~^send_byte_in;
                repeat (BIT) @(posedge clk_in);
            end
            line_out <= 1'b1;
            repeat (BIT) @(posedge clk_in);
        end
    end

    // Samples each bit in its middle after a start edge
    always @(negedge line_in) begin
        v = 8'h00;
        repeat (BIT / 2) @(posedge clk_in);
        for (k = 0; k < nbits_in; k++) begin
            repeat (BIT) @(posedge clk_in);
            v[k] = line_in;
        end
        // A wrong parity bit spoils the reported character
        if (par_in[0]) begin
            repeat (BIT) @(posedge clk_in);
            if (line_in !== (par_in[1] ? ^v : ~^v))
                v = ~v;
        end
        got_byte_out <= v;
        got_out <= 1'b1;
        @(posedge clk_in);
        got_out <= 1'b0;
    end
endmodule

`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench of the serial buffer path
// Assumes: Divisor 4 and receive sample clock of clk/4 give 64-clock bits
// Notes:   Read answers and peer characters are checked from queues
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready, pslverr, serial_out_pin, serial_in_pin, baud, irq, got;
    logic [31:0] prdata;
    logic [7:0]  got_byte;
    logic [1:0]  rck = 2'h0;
    logic [3:0]  nbits = 4'h8;
    logic        send = 1'b0;
    logic [7:0]  send_byte = 8'h00;
    logic [1:0]  par = 2'h0;
    logic        tie = 1'b0;
    logic [4:0]  lc[4] = '{5'h04, 5'h09, 5'h02, 5'h1f};
    logic [7:0]  b, m;
    logic [32:0] rd_q[$];
    logic [7:0]  tx_q[$];
    int          mismatches = 0;
    int          checked = 0;
    int          c, n;

    always #10 clk = ~clk;
    // Receive sample clock: two cycles high, two low
    always @(posedge clk) rck <= rck + 2'h1;

    uart_buffer_path uart_buffer_path_i (
        .clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
        .prdata_out(prdata), .pslverr_out(pslverr),
        .rx_sample_clock_in(tie ? baud : rck[1]),
        .serial_in_pin_in(serial_in_pin), .serial_out_pin_out(serial_out_pin), .baud_clock_out(baud),
        .interrupt_out(irq));
    serial_peer serial_peer_i (
        .clk_in(clk), .line_in(serial_out_pin), .line_out(serial_in_pin), .nbits_in(nbits), .send_in(send),
        .send_byte_in(send_byte), .par_in(par), .got_out(got), .got_byte_out(got_byte));

    task automatic end_sim();
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic timeout();
        mismatches++;
        end_sim();
    endtask

    task automatic chk(input logic [32:0] got_v, input logic [32:0] exp_v);
        checked++;
        if (got_v !== exp_v) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    // One bus transfer; a read notes {error, data} expected
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr)
            rd_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++)
            @(posedge clk);
        if (k == 20)
            timeout();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait for an interrupt level or for all sent characters
    task automatic wait_for(input logic lvl, input logic use_q);
        int k;
        for (k = 0; k < 4000; k++) begin
            @(posedge clk);
            if (use_q ? tx_q.size() == 0 : irq === lvl)
                break;
        end
        if (k == 4000)
            timeout();
    endtask

    // Takes the oldest note whenever a result appears
    always @(posedge clk) begin
        if (pready === 1'b1 && pwrite === 1'b0)
            chk({pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 33'h1ffffffff);
        if (got === 1'b1)
            chk({25'h0, got_byte}, tx_q.size() ? {25'h0, tx_q.pop_front()} : 33'h1ffffffff);
    end

    initial begin
        b = 8'($urandom(32'haca74150));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h0c, 32'h0, 33'h3);
        apb(1'b0, 8'h08, 32'h0, 33'h2);
        apb(1'b0, 8'h04, 32'h0, 33'h0);
        apb(1'b0, 8'h24, 32'h0, 33'h100000000);
        apb(1'b1, 8'h18, {24'h0, b}, 33'h0);
        apb(1'b0, 8'h18, 32'h0, {25'h0, b});
        apb(1'b0, 8'h08, 32'h0, 33'h2);
        apb(1'b1, 8'h04, 32'h2, 33'h0);
        repeat (3) @(posedge clk);
        chk({32'h0, irq}, 33'h1);
        b = 8'($urandom());
        tx_q.push_back(b);
        apb(1'b1, 8'h00, {24'h0, b}, 33'h0);
        repeat (3) @(posedge clk);
        chk({32'h0, irq}, 33'h0);
        apb(1'b0, 8'h08, 32'h0, 33'h0);
        apb(1'b1, 8'h14, 32'h0, 33'h0);
        apb(1'b1, 8'h10, 32'h4, 33'h0);
        for (n = 0; n < 100 && baud !== 1'b1; n++)
            @(posedge clk);
        @(posedge clk);
        for (n = 1; n < 100 && baud !== 1'b1; n++)
            @(posedge clk);
        chk(33'(n), 33'h4);
        b = 8'($urandom());
        tx_q.push_back(b);
        apb(1'b1, 8'h00, {24'h0, b}, 33'h0);
        apb(1'b0, 8'h08, 32'h0, 33'h0);
        wait_for(1'b1, 1'b0);
        wait_for(1'b0, 1'b1);
        apb(1'b1, 8'h08, 32'h2, 33'h0);
        apb(1'b0, 8'h08, 32'h0, 33'h0);
        apb(1'b1, 8'h04, 32'h1, 33'h0);
        // Every word length with mixed stop and parity settings, one character each way;
        // the last pass runs the receiver from the baud output
        for (c = 0; c < 4; c++) begin
            m = 8'hff >> (3 - c);
            nbits <= 4'(c + 5);
            par <= lc[c][4:3];
            tie <= (c == 3);
            apb(1'b1, 8'h0c, {27'h0, lc[c]}, 33'h0);
            b = 8'($urandom());
            tx_q.push_back(b & m);
            apb(1'b1, 8'h00, {24'h0, b}, 33'h0);
            wait_for(1'b0, 1'b1);
            b = 8'($urandom()) & m;
            send_byte <= b;
            send <= 1'b1;
            @(posedge clk);
            send <= 1'b0;
            wait_for(1'b1, 1'b0);
            apb(1'b0, 8'h00, 32'h0, {25'h0, b});
            apb(1'b0, 8'h1c, 32'h0, 33'h6);
            repeat (3) @(posedge clk);
            chk({32'h0, irq}, 33'h0);
        end
        end_sim();
    end
endmodule

`default_nettype wire

// ==== bench/uart_buffer_path_asserts.sv ====
// Purpose: Port checks of the serial buffer path
// Assumes: Bound to every uart_buffer_path instance
// Notes:   APB answer timing and transmit bit timing
`timescale 1ns/1ps
`default_nettype none

module uart_buffer_path_asserts (
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic [31:0] prdata_out,
    input wire logic        pslverr_out,
    input wire logic        rx_sample_clock_in,
    input wire logic        serial_in_pin_in,
    input wire logic        serial_out_pin_out,
    input wire logic        baud_clock_out,
    input wire logic        interrupt_out
);
    // One domain, reset masks every check
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // Phases of one bus transfer
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_access;
        psel_in && penable_in;
    endsequence

    a_ready_wait: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready_out |-> s_access and $past(penable_in))
        else $error("ready outside an access phase");
    a_idle_data: assert property (!pready_out |-> prdata_out == 32'h0 && !pslverr_out)
        else $error("read data or error outside ready");
    a_err_map: assert property (pready_out && paddr_in[1:0] == 2'h0 |->
        pslverr_out == (paddr_in[7:5] != 3'h0))
        else $error("error flag does not match address map");
    a_err_data: assert property (pslverr_out |-> prdata_out == 32'h0)
        else $error("data returned with error");
    a_scratch_width: assert property (pready_out && !pwrite_in && paddr_in == 8'h18 |->
        prdata_out[31:8] == 24'h0)
        else $error("scratch wider than a byte");
    a_bit_hold: assert property ($changed(serial_out_pin_out) |=>
        $stable(serial_out_pin_out) [*8])
        else $error("serial bit too short");
    a_tick_cause: assert property ($changed(serial_out_pin_out) |->
        $past(baud_clock_out) || $past(baud_clock_out, 2))
        else $error("serial output moved without baud tick");
endmodule

bind uart_buffer_path uart_buffer_path_asserts uart_buffer_path_asserts_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out),
    .pslverr_out(pslverr_out), .rx_sample_clock_in(rx_sample_clock_in),
    .serial_in_pin_in(serial_in_pin_in), .serial_out_pin_out(serial_out_pin_out),
    .baud_clock_out(baud_clock_out), .interrupt_out(interrupt_out)
);

`default_nettype wire

// ==== verilog/uart_buffer_path.sv ====
// Purpose: Receive and transmit buffer path of a serial comms element
// Assumes: clk_in is the reference clock, rx sample clock is slower than clk_in/2
// Notes:   APB slave, sticky events with mask, one level interrupt
//
// Summary of operation
// - The receiver advances only on edges of the 16x receive sample clock input.
// - Incoming bits on the serial input are shifted into a receive shift register.
// - A finished character is loaded in parallel into the receive holding buffer.
// - Loading the receive holding buffer raises the enabled receive interrupt.
// - Reading the receive holding buffer clears the receive interrupt.
// - An 8-bit scratchpad holds any written value and affects nothing else.
// - The transmitter advances only on ticks of the baud generator output.
// - A character moves from holding buffer to shift register only when idle.
// - The transmit shift register is serialised onto the serial output.
// - An empty transmit holding buffer raises the enabled transmit interrupt.
// - Writing a character to the transmit holding buffer clears that interrupt.
// - Word length and parity for both directions, and transmit stop bits, come from line control.
// - The baud generator divides the reference clock by a 16-bit divisor.
// - Writing either divisor byte reloads the baud counter at once.
`timescale 1ns/1ps
`default_nettype none
`include "uart_defines.svh"

module uart_buffer_path (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic [31:0]      prdata_out,
    output logic             pslverr_out,
    input  wire logic        rx_sample_clock_in,
    input  wire logic        serial_in_pin_in,
    output logic             serial_out_pin_out,
    output logic             baud_clock_out,
    output logic             interrupt_out
);

    uart_pkg::core_s q;
    uart_pkg::core_s next_q;

    logic [2:0] last_bit;
    logic       access;
    logic       done;
    logic       addr_ok;
    logic       rx_tick;
    logic [7:0] rx_data;
    logic       rx_exp_par;
    logic [7:0] word_mask;
    logic       tx_data_par;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Last data bit index from word length code
    assign last_bit = {1'b1, q.line_ctrl[`LC_WLEN_MSB:`LC_WLEN_LSB]};
    // Data bits of the current word length; unused holding bits stay out of parity
    assign word_mask   = 8'hff >> (3'h7 - last_bit);
    assign tx_data_par = ^(q.tx_hold & word_mask);
    assign access   = psel_in & penable_in;
    assign done     = access & q.pready;
    // Rising edge of the synchronised sample clock
    assign rx_tick  = q.rck_s2 & ~q.rck_s3;
    assign rx_data  = q.rx_sh;
    // Expected parity over received data
    assign rx_exp_par = q.line_ctrl[`LC_PAR_EVEN] ? ^rx_data : ~^rx_data;

    always_comb begin
        case (paddr_in)
            `OFS_DATA, `OFS_MASK, `OFS_STATUS, `OFS_LINE_CTRL, `OFS_DIV_LO,
            `OFS_DIV_HI, `OFS_SCRATCH, `OFS_LINE_STATE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_q = q;

        // Synchronisers for the pins
        next_q.rck_s1 = rx_sample_clock_in;
        next_q.rck_s2 = q.rck_s1;
        next_q.rck_s3 = q.rck_s2;
        next_q.sin_s1 = serial_in_pin_in;
        next_q.sin_s2 = q.sin_s1;

        // Baud divider, one tick per divisor count
        next_q.baud_tick = 1'b0;
        if (q.baud_cnt <= 16'h0001) begin
            next_q.baud_cnt  = {q.div_hi, q.div_lo};
            next_q.baud_tick = ({q.div_hi, q.div_lo} != 16'h0000);
        end else begin
            next_q.baud_cnt = q.baud_cnt - 16'h0001;
        end

        // Software clear of events, write one to clear
        if (done && pwrite_in && paddr_in == `OFS_STATUS) begin
            next_q.status = q.status & ~pwdata_in[1:0];
        end

        // Transmitter, steps on baud ticks only
        if (q.baud_tick) begin
            next_q.tx_cnt = q.tx_cnt + 5'h01;
            case (q.tx_st)
                uart_pkg::SER_IDLE: begin
                    next_q.tx_cnt = 5'h00;
                    if (!q.thr_empty) begin
                        next_q.tx_sh     = q.tx_hold;
                        next_q.tx_par    = q.line_ctrl[`LC_PAR_EVEN] ? tx_data_par : ~tx_data_par;
                        next_q.thr_empty = 1'b1;
                        next_q.status[`EV_TX_EMPTY] = 1'b1;
                        next_q.serial_out_pin      = 1'b0;
                        next_q.tx_st     = uart_pkg::SER_START;
                    end
                end
                uart_pkg::SER_START: begin
                    if (q.tx_cnt[3:0] == `TICKS_BIT_LAST) begin
                        next_q.tx_cnt = 5'h00;
                        next_q.tx_bit = 3'h0;
                        next_q.serial_out_pin   = q.tx_sh[0];
                        next_q.tx_st  = uart_pkg::SER_DATA;
                    end
                end
                uart_pkg::SER_DATA: begin
                    if (q.tx_cnt[3:0] == `TICKS_BIT_LAST) begin
                        next_q.tx_cnt = 5'h00;
                        if (q.tx_bit == last_bit) begin
                            if (q.line_ctrl[`LC_PAR_EN]) begin
                                next_q.serial_out_pin  = q.tx_par;
                                next_q.tx_st = uart_pkg::SER_PARITY;
                            end else begin
                                next_q.serial_out_pin  = 1'b1;
                                next_q.tx_st = uart_pkg::SER_STOP;
                            end
                        end else begin
                            next_q.tx_bit = q.tx_bit + 3'h1;
                            next_q.tx_sh  = {1'b0, q.tx_sh[7:1]};
                            next_q.serial_out_pin   = q.tx_sh[1];
                        end
                    end
                end
                uart_pkg::SER_PARITY: begin
                    if (q.tx_cnt[3:0] == `TICKS_BIT_LAST) begin
                        next_q.tx_cnt = 5'h00;
                        next_q.serial_out_pin   = 1'b1;
                        next_q.tx_st  = uart_pkg::SER_STOP;
                    end
                end
                uart_pkg::SER_STOP: begin
                    // Stop length 1, 1.5 for 5-bit words, or 2
                    if ((!q.line_ctrl[`LC_STOP2] && q.tx_cnt == `STOP1_LAST) ||
                        (q.line_ctrl[`LC_STOP2] && last_bit == 3'h4 &&
                         q.tx_cnt == `STOP15_LAST) ||
                        (q.line_ctrl[`LC_STOP2] && q.tx_cnt == `STOP2_LAST)) begin
                        next_q.tx_cnt = 5'h00;
                        next_q.tx_st  = uart_pkg::SER_IDLE;
                    end
                end
                default: begin
                    next_q.serial_out_pin  = 1'b1;
                    next_q.tx_st = uart_pkg::SER_IDLE;
                end
            endcase
        end

        // Register writes take effect at the completing edge
        if (done && pwrite_in) begin
            case (paddr_in)
                `OFS_DATA: begin
                    next_q.tx_hold   = pwdata_in[7:0];
                    next_q.thr_empty = 1'b0;
                    next_q.status[`EV_TX_EMPTY] = 1'b0;
                end
                `OFS_MASK:      next_q.mask = pwdata_in[1:0];
                `OFS_LINE_CTRL: next_q.line_ctrl = pwdata_in[4:0];
                `OFS_DIV_LO: begin
                    next_q.div_lo   = pwdata_in[7:0];
                    next_q.baud_cnt = {q.div_hi, pwdata_in[7:0]};
                end
                `OFS_DIV_HI: begin
                    next_q.div_hi   = pwdata_in[7:0];
                    next_q.baud_cnt = {pwdata_in[7:0], q.div_lo};
                end
                `OFS_SCRATCH:   next_q.scratch = pwdata_in[7:0];
                default: begin
                end
            endcase
        end

        // Reading the receive buffer empties it
        if (done && !pwrite_in && paddr_in == `OFS_DATA) begin
            next_q.rx_full = 1'b0;
            next_q.status[`EV_RX_AVAIL] = 1'b0;
        end

        // Receiver, steps on sample clock edges; sets win over clears above
        if (rx_tick) begin
            next_q.rx_cnt = q.rx_cnt + 4'h1;
            case (q.rx_st)
                uart_pkg::SER_IDLE: begin
                    next_q.rx_cnt = 4'h0;
                    if (!q.sin_s2) begin
                        next_q.rx_st = uart_pkg::SER_START;
                    end
                end
                uart_pkg::SER_START: begin
                    // Mid start bit check rejects false starts
                    if (q.rx_cnt == `TICKS_HALF_LAST) begin
                        next_q.rx_cnt = 4'h0;
                        next_q.rx_bit = 3'h0;
                        next_q.rx_sh  = 8'h00;
                        next_q.rx_st  = q.sin_s2 ? uart_pkg::SER_IDLE : uart_pkg::SER_DATA;
                    end
                end
                uart_pkg::SER_DATA: begin
                    if (q.rx_cnt == `TICKS_BIT_LAST) begin
                        next_q.rx_sh[q.rx_bit] = q.sin_s2;
                        next_q.rx_bit = q.rx_bit + 3'h1;
                        if (q.rx_bit == last_bit) begin
                            next_q.rx_st = q.line_ctrl[`LC_PAR_EN] ? uart_pkg::SER_PARITY
                                                                    : uart_pkg::SER_STOP;
                        end
                    end
                end
                uart_pkg::SER_PARITY: begin
                    if (q.rx_cnt == `TICKS_BIT_LAST) begin
                        next_q.rx_par = q.sin_s2;
                        next_q.rx_st  = uart_pkg::SER_STOP;
                    end
                end
                uart_pkg::SER_STOP: begin
                    if (q.rx_cnt == `TICKS_BIT_LAST) begin
                        next_q.rx_hold   = rx_data;
                        next_q.rx_full   = 1'b1;
                        next_q.frame_err = ~q.sin_s2;
                        next_q.par_err   = q.line_ctrl[`LC_PAR_EN] & (q.rx_par != rx_exp_par);
                        next_q.status[`EV_RX_AVAIL] = 1'b1;
                        next_q.rx_st     = uart_pkg::SER_IDLE;
                    end
                end
                default: next_q.rx_st = uart_pkg::SER_IDLE;
            endcase
        end

        // APB answer: one wait state, data captured before the answer
        next_q.pready  = access & ~q.pready;
        next_q.pslverr = access & ~q.pready & ~addr_ok;
        next_q.prdata  = 32'h0000_0000;
        if (access && !q.pready && !pwrite_in) begin
            case (paddr_in)
                `OFS_DATA:      next_q.prdata[7:0] = q.rx_hold;
                `OFS_MASK:      next_q.prdata[1:0] = q.mask;
                `OFS_STATUS:    next_q.prdata[1:0] = q.status;
                `OFS_LINE_CTRL: next_q.prdata[4:0] = q.line_ctrl;
                `OFS_DIV_LO:    next_q.prdata[7:0] = q.div_lo;
                `OFS_DIV_HI:    next_q.prdata[7:0] = q.div_hi;
                `OFS_SCRATCH:   next_q.prdata[7:0] = q.scratch;
                `OFS_LINE_STATE: begin
                    next_q.prdata[`LS_RX_FULL]   = q.rx_full;
                    next_q.prdata[`LS_THR_EMPTY] = q.thr_empty;
                    next_q.prdata[`LS_TSR_IDLE]  = (q.tx_st == uart_pkg::SER_IDLE);
                    next_q.prdata[`LS_FRAME_ERR] = q.frame_err;
                    next_q.prdata[`LS_PAR_ERR]   = q.par_err;
                end
                default: next_q.prdata = 32'h0000_0000;
            endcase
        end

        // Level interrupt from unmasked events
        next_q.irq = |(next_q.status & next_q.mask);

        // Synchronous reset values
        if (sys_rst_in) begin
            next_q           = '0;
            next_q.rx_st     = uart_pkg::SER_IDLE;
            next_q.tx_st     = uart_pkg::SER_IDLE;
            next_q.line_ctrl = `RST_LINE_CTRL;
            next_q.mask      = `RST_MASK;
            next_q.status    = `RST_STATUS;
            next_q.div_lo    = `RST_DIV;
            next_q.div_hi    = `RST_DIV;
            next_q.thr_empty = 1'b1;
            next_q.serial_out_pin      = 1'b1;
            next_q.sin_s1    = 1'b1;
            next_q.sin_s2    = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        q <= next_q;
    end

    // Outputs straight from flip-flops
    assign pready_out         = q.pready;
    assign prdata_out         = q.prdata;
    assign pslverr_out        = q.pslverr;
    assign serial_out_pin_out = q.serial_out_pin;
    assign baud_clock_out     = q.baud_tick;
    assign interrupt_out      = q.irq;

endmodule

`default_nettype wire

// ==== verilog/uart_defines.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_DATA       8'h00
`define OFS_MASK       8'h04
`define OFS_STATUS     8'h08
`define OFS_LINE_CTRL  8'h0c
`define OFS_DIV_LO     8'h10
`define OFS_DIV_HI     8'h14
`define OFS_SCRATCH    8'h18
`define OFS_LINE_STATE 8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EV_RX_AVAIL    0
`define EV_TX_EMPTY    1
`define LC_WLEN_LSB    0
`define LC_WLEN_MSB    1
`define LC_STOP2       2
`define LC_PAR_EN      3
`define LC_PAR_EVEN    4
`define LS_RX_FULL     0
`define LS_THR_EMPTY   1
`define LS_TSR_IDLE    2
`define LS_FRAME_ERR   3
`define LS_PAR_ERR     4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_LINE_CTRL  5'h03
`define RST_MASK       2'h0
`define RST_STATUS     2'h2
`define RST_DIV        8'h00

// ----------------------------------------------------------------
// Timing counts in 16x ticks
// ----------------------------------------------------------------
`define TICKS_BIT_LAST   4'hf
`define TICKS_HALF_LAST  4'h7
`define STOP1_LAST       5'h0f
`define STOP15_LAST      5'h17
`define STOP2_LAST       5'h1f

`endif

// ==== verilog/uart_pkg.sv ====
// Purpose: Types of the serial buffer path
// Assumes: Used as uart_pkg::name, never imported
// Notes:   One packed struct holds all state of the core
package uart_pkg;

    // Serial engine states, shared by receiver and transmitter
    typedef enum logic [2:0] {
        SER_IDLE   = 3'b000,
        SER_START  = 3'b001,
        SER_DATA   = 3'b010,
        SER_PARITY = 3'b011,
        SER_STOP   = 3'b100
    } ser_state_e;

    typedef struct packed {
        logic        rck_s1;
        logic        rck_s2;
        logic        rck_s3;
        logic        sin_s1;
        logic        sin_s2;
        logic [15:0] baud_cnt;
        logic        baud_tick;
        logic [7:0]  div_lo;
        logic [7:0]  div_hi;
        logic [4:0]  line_ctrl;
        logic [1:0]  mask;
        logic [1:0]  status;
        logic [7:0]  scratch;
        logic [7:0]  rx_hold;
        logic        rx_full;
        logic        frame_err;
        logic        par_err;
        ser_state_e  rx_st;
        logic [3:0]  rx_cnt;
        logic [2:0]  rx_bit;
        logic [7:0]  rx_sh;
        logic        rx_par;
        logic [7:0]  tx_hold;
        logic        thr_empty;
        ser_state_e  tx_st;
        logic [4:0]  tx_cnt;
        logic [2:0]  tx_bit;
        logic [7:0]  tx_sh;
        logic        tx_par;
        logic        serial_out_pin;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        irq;
    } core_s;

endpackage
